/* File: rtl/spz_serial_port_zero_pins.sv */
// Purpose: Pin mux, direction control and bit engine of serial port zero
// Assumes: External pins are asynchronous; sclk sampled by core clock
// Notes:   Data launched on falling sclk, latched on rising sclk
`timescale 1ns/1ps

// Overview of operation
// - Data-out pin: master drives, slave receives
// - Master launches bit half period early
// - Data-in pin: master samples, selected slave drives
// - Unselected slave releases data-in pin
// - Slave launches first bit at select, later bits on falling clock
// - Slave transfers only while selected
// - Pins default to serial role after reset
// - Pull-ups from enable bits 5,6,7
// - Port function pins individually input/output
// - Clock pin output as master, input slave
module spz_serial_port_zero_pins (
  input  wire logic                    clock,            // Core clock
  input  wire logic                    reset_n,          // Async reset
  input  wire logic                    clk_en,           // Freeze when low
  input  wire logic                    master_mode,      // 1 = master
  input  wire logic                    func_write,       // Load pin function
  input  wire logic [2:0]              func_data,        // 1 = port function
  input  wire logic                    pur_write,        // Load pull-ups
  input  wire logic [7:0]              pur_data,         // Pull-up bits
  input  wire logic [2:0]              gpio_dir,         // 1 = output
  input  wire logic [2:0]              gpio_out,         // Port output value
  output logic      [2:0]              gpio_in,          // Port input value
  input  wire logic                    tx_start,         // Master start
  input  wire logic [7:0]              tx_data,          // Word to send
  output logic      [7:0]              rx_data,          // Received word
  output logic                         rx_valid,         // Word done pulse
  output logic                         busy,             // Transfer active
  input  wire logic                    port0_master_out_pin_i, // Pin in
  output spz_pkg::spz_drive_t          port0_master_out_pin_d, // Pin drive
  input  wire logic                    port0_master_in_pin_i,  // Pin in
  output spz_pkg::spz_drive_t          port0_master_in_pin_d,  // Pin drive
  input  wire logic                    port0_slave_select_i,   // Pin in
  output spz_pkg::spz_drive_t          port0_slave_select_d,   // Pin drive
  input  wire logic                    port0_serial_clock_i,   // Pin in
  output spz_pkg::spz_drive_t          port0_serial_clock_d,   // Pin drive
  output logic      [2:0]              pullup_on         // Pad pull-ups
);
  import spz_pkg::*;

  // ==========================================================
  // Input synchronisers
  logic [3:0]  sync1_reg;
  logic [3:0]  sync2_reg;
  logic        sclk_d_reg;
  logic        sel_d_reg;
  wire  [3:0]  pins_raw = {port0_serial_clock_i, port0_slave_select_i,
                           port0_master_in_pin_i, port0_master_out_pin_i};

  // Clock sits just above the three muxed pins
  wire mosi_s = sync2_reg[PIN_MOSI];
  wire miso_s = sync2_reg[PIN_MISO];
  wire sclk_s = sync2_reg[PIN_N];
  wire selected = !sync2_reg[PIN_SS];

  // Clock bit resets low, its idle level, so no false edge after reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg  <= {1'b0, ~ZERO3};
      sync2_reg  <= {1'b0, ~ZERO3};
      sclk_d_reg <= 1'b0;
      sel_d_reg  <= 1'b0;
    end else if (clk_en) begin
      sync1_reg  <= pins_raw;
      sync2_reg  <= sync1_reg;
      sclk_d_reg <= sclk_s;
      sel_d_reg  <= selected;
    end
  end

  // ==========================================================
  // Pin function and pull-up registers
  logic [2:0]        func_reg;
  logic [PUR_W-1:0]  pur_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      func_reg <= FUNC_RESET;
    else if (clk_en && func_write)
      func_reg <= func_data;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      pur_reg <= PUR_RESET;
    else if (clk_en && pur_write)
      pur_reg <= pur_data;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n)
      pullup_on <= ~ZERO3;
    else if (clk_en)
      pullup_on <= {pur_reg[PUR_SS_BIT], pur_reg[PUR_MISO_BIT],
                    pur_reg[PUR_MOSI_BIT]};
  end

  wire spi_mosi = (func_reg[PIN_MOSI] == FUNC_SPI);
  wire spi_miso = (func_reg[PIN_MISO] == FUNC_SPI);
  wire spi_ss   = (func_reg[PIN_SS] == FUNC_SPI);
  wire slave_on = !master_mode && spi_ss && selected;

  // ==========================================================
  // Bit engine
  spz_state_t         state_reg;
  logic [2:0]         half_reg;
  logic [2:0]         bit_reg;
  logic [DATA_W-1:0]  shift_reg;
  logic               rx_bit_reg;
  logic               sclk_reg;

  wire half_tick = (half_reg == HALF_LAST);
  wire s_rise    = sclk_s && !sclk_d_reg;
  wire s_fall    = !sclk_s && sclk_d_reg;
  wire m_rise    = (state_reg == ST_SHIFT) && half_tick && !sclk_reg;
  wire m_fall    = (state_reg == ST_SHIFT) && half_tick && sclk_reg;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg  <= ST_IDLE;
      half_reg   <= CNT_ZERO;
      bit_reg    <= CNT_ZERO;
      shift_reg  <= DATA_ZERO;
      rx_bit_reg <= 1'b0;
      sclk_reg   <= 1'b0;
      rx_data    <= DATA_ZERO;
      rx_valid   <= 1'b0;
      busy       <= 1'b0;
    end else if (clk_en) begin
      rx_valid <= 1'b0;
      if (master_mode) begin
        case (state_reg)
          ST_IDLE: begin
            // first bit shows a half period early
            if (tx_start) begin
              shift_reg <= tx_data;
              bit_reg   <= CNT_ZERO;
              half_reg  <= CNT_ZERO;
              busy      <= 1'b1;
              state_reg <= ST_SHIFT;
            end
          end
          ST_SHIFT: begin
            half_reg <= half_tick ? CNT_ZERO : half_reg + BIT_ONE;
            if (half_tick)
              sclk_reg <= !sclk_reg;
            if (m_rise)
              rx_bit_reg <= miso_s;
            // next bit launched on falling edge
            if (m_fall) begin
              shift_reg <= {shift_reg[DATA_W-2:0], rx_bit_reg};
              bit_reg   <= bit_reg + BIT_ONE;
              if (bit_reg == BIT_LAST)
                state_reg <= ST_DONE;
            end
          end
          ST_DONE: begin
            rx_data   <= shift_reg;
            rx_valid  <= 1'b1;
            busy      <= 1'b0;
            state_reg <= ST_IDLE;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end else begin
        state_reg <= ST_IDLE;
        sclk_reg  <= 1'b0;
        half_reg  <= CNT_ZERO;
        busy      <= slave_on;
        // slave loads first bit at select
        if (slave_on && !sel_d_reg) begin
          shift_reg <= tx_data;
          bit_reg   <= CNT_ZERO;
        end else if (slave_on) begin
          if (s_rise)
            rx_bit_reg <= mosi_s;
          if (s_fall) begin
            shift_reg <= {shift_reg[DATA_W-2:0], rx_bit_reg};
            bit_reg   <= bit_reg + BIT_ONE;
            if (bit_reg == BIT_LAST) begin
              rx_data  <= {shift_reg[DATA_W-2:0], rx_bit_reg};
              rx_valid <= 1'b1;
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // Pin drivers, all registered
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port0_master_out_pin_d <= DRIVE_OFF;
      port0_master_in_pin_d  <= DRIVE_OFF;
      port0_slave_select_d   <= DRIVE_OFF;
      port0_serial_clock_d   <= DRIVE_OFF;
      gpio_in                <= ZERO3;
    end else if (clk_en) begin
      gpio_in <= sync2_reg[2:0];
      if (!spi_mosi)
        port0_master_out_pin_d <= '{out: gpio_out[PIN_MOSI],
                                    oe:  gpio_dir[PIN_MOSI]};
      else
        port0_master_out_pin_d <= '{out: shift_reg[DATA_W-1],
                                    oe:  master_mode};
      if (!spi_miso)
        port0_master_in_pin_d <= '{out: gpio_out[PIN_MISO],
                                   oe:  gpio_dir[PIN_MISO]};
      else
        port0_master_in_pin_d <= '{out: shift_reg[DATA_W-1],
                                   oe:  slave_on};
      if (!spi_ss)
        port0_slave_select_d <= '{out: gpio_out[PIN_SS],
                                  oe:  gpio_dir[PIN_SS]};
      else
        port0_slave_select_d <= DRIVE_OFF;
      port0_serial_clock_d <= '{out: sclk_reg, oe: master_mode};
    end
  end

  // ==========================================================
  // Checks
  a_mosi_master_drive: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && spi_mosi |=> port0_master_out_pin_d.oe == $past(master_mode))
    else $error("data-out enable does not follow mode");
  a_mosi_launch_early: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && m_rise |-> ##1 $stable(port0_master_out_pin_d.out))
    else $error("data-out changed at latch edge");
  a_miso_master_input: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && master_mode && spi_miso |=> !port0_master_in_pin_d.oe)
    else $error("master drives data-in pin");
  a_miso_unselected_off: assert property (@(posedge clock)
    disable iff (!reset_n)
    clk_en && spi_miso && !master_mode && !selected
    |=> !port0_master_in_pin_d.oe)
    else $error("unselected slave drives data-in");
  a_slave_launch_fall: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && $past(slave_on && sel_d_reg) && $changed(shift_reg)
    |-> $past(s_fall))
    else $error("slave shifted off falling edge");
  a_slave_ignore_idle: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && !master_mode && !slave_on |=> !rx_valid)
    else $error("word accepted while not selected");
  a_pullup_follow: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && pur_write ##1 clk_en |=> pullup_on ==
      {$past(pur_data[PUR_SS_BIT], 2), $past(pur_data[PUR_MISO_BIT], 2),
       $past(pur_data[PUR_MOSI_BIT], 2)})
    else $error("pull-up not from its enable bit");
  a_gpio_direction: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en && !spi_miso
    |=> port0_master_in_pin_d.oe == $past(gpio_dir[PIN_MISO]))
    else $error("port function direction ignored");
  a_sclk_direction: assert property (@(posedge clock) disable iff (!reset_n)
    clk_en |=> port0_serial_clock_d.oe == $past(master_mode))
    else $error("clock pin direction wrong");
endmodule

/* File: rtl/spz_pkg.sv */
// Purpose: Shared constants and types for the serial port zero pin block
// Assumes: 250 MHz core clock, 8-bit serial words
// Notes:   Pull-up bit positions follow the port E pull-up register
package spz_pkg;
  localparam int          DATA_W        = 8;
  localparam int          PUR_W         = 8;
  localparam int          PUR_MOSI_BIT  = 5;
  localparam int          PUR_MISO_BIT  = 6;
  localparam int          PUR_SS_BIT    = 7;
  localparam logic [7:0]  PUR_RESET     = 8'hFF;
  localparam int          PIN_N         = 3;
  localparam int          PIN_MOSI      = 0;
  localparam int          PIN_MISO      = 1;
  localparam int          PIN_SS        = 2;
  localparam logic        FUNC_SPI      = 1'b0;
  localparam logic        FUNC_GPIO     = 1'b1;
  localparam logic [2:0]  FUNC_RESET    = 3'h0;
  localparam logic [2:0]  ZERO3         = 3'h0;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          SCLK_HALF_NS  = 16;
  localparam int          HALF_CNT      = (SCLK_HALF_NS + CLK_PERIOD_NS - 1)
                                          / CLK_PERIOD_NS;
  localparam logic [2:0]  HALF_LAST     = 3'(HALF_CNT - 1);
  localparam logic [2:0]  CNT_ZERO      = 3'h0;
  localparam logic [2:0]  BIT_LAST      = 3'(DATA_W - 1);
  localparam logic [2:0]  BIT_ONE       = 3'h1;
  localparam logic [7:0]  DATA_ZERO     = 8'h00;

  typedef struct packed {
    logic out;
    logic oe;
  } spz_drive_t;

  localparam spz_drive_t DRIVE_OFF = '{out: 1'b0, oe: 1'b0};

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } spz_state_t;
endpackage

/* File: verification/spz_far_end.sv */
// Purpose: Far-side serial peer, slave or master by device mode
// Assumes: Clock idle low, latch on rise, launch on fall
// Notes:   Link clock period 64 ns in master role, phase free of the core clock
`timescale 1ns/1ps
module spz_far_end (
  sclk,     // Clock wire
  mosi,     // Data-out wire
  miso,     // Data-in wire
  m_sclk,   // Our clock as master
  m_mosi,   // Our data as master
  m_sel_n,  // Our select, active low
  s_miso,   // Our data as slave
  s_got     // Word taken as slave
);
  input  wire logic       sclk;
  input  wire logic       mosi;
  input  wire logic       miso;
  output logic            m_sclk = 1'b0;
  output logic            m_mosi = 1'b0;
  output logic            m_sel_n = 1'b1;
  output logic            s_miso;
  output logic [7:0]      s_got = 8'h00;
  logic        [7:0]      sh = 8'h00;
  assign s_miso = sh[7];
  always @(negedge sclk) sh <= {sh[6:0], ~sh[0]};
  always @(posedge sclk) s_got <= {s_got[6:0], mosi};
  task automatic load(input logic [7:0] w);
    sh = w;
  endtask
  // ==========================================
  // Master role
  // select low, bit ahead of rise
  task automatic xfer(input logic sel, input logic [7:0] w,
                      output logic [7:0] r);
    #1.3 m_sel_n = ~sel;
    #64;
    for (int i = 7; i >= 0; i--) begin
      m_mosi = w[i];
      #32 m_sclk = 1'b1;
      r[i] = miso;
      #32 m_sclk = 1'b0;
    end
    #64 m_sel_n = 1'b1;
  endtask
endmodule

/* File: verification/tb.sv */
// Purpose: Self-checking bench for the serial port zero pin block
// Assumes: Far-side peer always drives select, other lines only in its role
// Notes:   Expected words queued by drivers, checked on rx_valid
`timescale 1ns/1ps
module tb;
  import spz_pkg::*;
  logic       clock, rx_valid, busy, mo_w, mi_w, ss_w, sc_w;
  logic       m_sclk, m_mosi, m_sel_n, s_miso;
  logic       reset_n = 1'b0, master_mode = 1'b1, tick = 1'b0;
  logic       clk_en = 1'b1;
  logic       func_write = 1'b0, pur_write = 1'b0, tx_start = 1'b0;
  logic [2:0] func_data = 3'h0, gpio_dir = 3'h0, gpio_out = 3'h0;
  logic [2:0] gpio_in, pullup_on;
  logic [7:0] pur_data = 8'h00, tx_data = 8'h00, rx_data, s_got, w, r;
  spz_drive_t mo_d, mi_d, ss_d, sc_d;
  logic [7:0] exp_q[$];
  int         fails = 0, samples_checked = 0;

  spz_serial_port_zero_pins i_dut (
    .clock(clock), .reset_n(reset_n), .clk_en(clk_en),
    .master_mode(master_mode), .func_write(func_write),
    .func_data(func_data), .pur_write(pur_write), .pur_data(pur_data),
    .gpio_dir(gpio_dir), .gpio_out(gpio_out), .gpio_in(gpio_in),
    .tx_start(tx_start), .tx_data(tx_data), .rx_data(rx_data),
    .rx_valid(rx_valid), .busy(busy),
    .port0_master_out_pin_i(mo_w), .port0_master_out_pin_d(mo_d),
    .port0_master_in_pin_i(mi_w), .port0_master_in_pin_d(mi_d),
    .port0_slave_select_i(ss_w), .port0_slave_select_d(ss_d),
    .port0_serial_clock_i(sc_w), .port0_serial_clock_d(sc_d),
    .pullup_on(pullup_on));
  spz_far_end i_far (
    .sclk(sc_w), .mosi(mo_w), .miso(mi_w), .m_sclk(m_sclk),
    .m_mosi(m_mosi), .m_sel_n(m_sel_n), .s_miso(s_miso), .s_got(s_got));

  // ==========================================
  // Wire levels; a released line without pull-up wobbles
  function automatic logic res(spz_drive_t d, logic oe2, logic v2,
                               logic pu, logic alt);
    return d.oe ? d.out : (oe2 ? v2 : (pu ? 1'b1 : alt));
  endfunction
  assign mo_w = res(mo_d, ~m_sel_n & ~master_mode, m_mosi,
                    pullup_on[0], tick);
  assign mi_w = res(mi_d, master_mode, s_miso, pullup_on[1], tick);
  assign ss_w = res(ss_d, 1'b1, m_sel_n, pullup_on[2], tick);
  assign sc_w = res(sc_d, ~master_mode, m_sclk, 1'b0, tick);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  always @(posedge clock) tick <= ~tick;

  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h got %h", n, e, g);
    end
  endtask
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) chk("rx_extra", 8'h00, 8'hFF);
      else chk("rx_data", exp_q.pop_front(), rx_data);
    end
  end
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge clock);
      n++;
    end
    if (n >= 300) begin
      fails++;
      end_sim();
    end
  endtask
  // Second start while busy must be dropped
  task automatic mxfer(input logic [7:0] t, input logic [7:0] s);
    i_far.load(s);
    exp_q.push_back(s);
    @(posedge clock);
    tx_data <= t;
    tx_start <= 1'b1;
    @(posedge clock);
    tx_start <= 1'b0;
    repeat (4) @(posedge clock);
    tx_data <= ~t;
    tx_start <= 1'b1;
    @(posedge clock);
    tx_start <= 1'b0;
    wait_idle();
    repeat (3) @(posedge clock);
    chk("far_got", t, s_got);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    w = 8'($urandom(56));
    repeat (19) @(posedge clock);
    chk("rst_oe", 8'h00, {4'h0, mo_d.oe, mi_d.oe, ss_d.oe, sc_d.oe});
    chk("rst_pu", 8'h07, {5'h00, pullup_on});
    @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    chk("mst_oe", 8'h09, {4'h0, mo_d.oe, mi_d.oe, ss_d.oe, sc_d.oe});
    for (int i = 0; i < 3; i++) mxfer(8'($urandom), 8'($urandom));
    master_mode <= 1'b0;
    repeat (4) @(posedge clock);
    chk("slv_oe", 8'h00, {4'h0, mo_d.oe, mi_d.oe, ss_d.oe, sc_d.oe});
    i_far.xfer(1'b0, 8'h5A, r);
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      tx_data <= 8'($urandom);
      w = 8'($urandom);
      exp_q.push_back(w);
      fork
        i_far.xfer(1'b1, w, r);
        begin
          #200;
          chk("miso_oe", 8'h01, {7'h00, mi_d.oe});
          chk("slv_busy", 8'h01, {7'h00, busy});
        end
      join
      chk("slv_tx", tx_data, r);
      repeat (8) @(posedge clock);
      chk("miso_off", 8'h00, {7'h00, mi_d.oe});
    end
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      pur_data <= 8'($urandom);
      pur_write <= 1'b1;
      @(posedge clock);
      pur_write <= 1'b0;
      repeat (3) @(posedge clock);
      chk("pullup", {5'h00, pur_data[7:5]}, {5'h00, pullup_on});
    end
    // Write strobe while frozen must leave pull-ups alone
    @(posedge clock);
    clk_en <= 1'b0;
    pur_data <= ~pur_data;
    pur_write <= 1'b1;
    @(posedge clock);
    pur_write <= 1'b0;
    @(posedge clock);
    clk_en <= 1'b1;
    repeat (3) @(posedge clock);
    chk("frozen", {5'h00, ~pur_data[7:5]}, {5'h00, pullup_on});
    func_data <= 3'h7;
    func_write <= 1'b1;
    @(posedge clock);
    func_write <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      gpio_dir <= 3'($urandom);
      gpio_out <= 3'($urandom);
      repeat (5) @(posedge clock);
      chk("gpio_oe", {5'h00, gpio_dir}, {5'h00, ss_d.oe, mi_d.oe, mo_d.oe});
      chk("gpio_in", {5'h00, gpio_dir & gpio_out},
          {5'h00, gpio_dir & gpio_in});
    end
    chk("rx_left", 8'h00, 8'(exp_q.size()));
    end_sim();
  end
endmodule
